// *** core/flash_host_pkg.sv ***
/*
  Types and constants of the flash host controller.
  Assumes one 20 MHz clock and x16 flash addressing.
*/
package flash_host_pkg;

  // ==========================================================================
  // Widths
  localparam int ADDR_W = 20;
  localparam int DATA_W = 16;
  localparam int TO_W   = 28;

  // ==========================================================================
  // Command set offered to the user side
  typedef enum logic [3:0] {
    CMD_READ,
    CMD_PROGRAM,
    CMD_CHIP_ERASE,
    CMD_SECTOR_ERASE,
    CMD_SUSPEND,
    CMD_RESUME,
    CMD_ID_ENTER,
    CMD_ID_EXIT_SHORT,
    CMD_ID_EXIT_LONG
  } cmd_t;

  typedef struct packed {
    cmd_t                cmd;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
  } req_t;

  typedef struct packed {
    logic                ceN;
    logic                oeN;
    logic                weN;
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   dqOut;
    logic                dqOe;
  } pins_t;

  typedef struct packed {
    logic [ADDR_W-1:0]   addr;
    logic [DATA_W-1:0]   data;
    logic                isWrite;
    logic                last;
  } step_t;

  // ==========================================================================
  // Command addresses and bytes
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK1   = 20'h0_0555;
  localparam logic [ADDR_W-1:0] ADDR_UNLOCK2   = 20'h0_02AA;
  localparam logic [ADDR_W-1:0] ADDR_ID_MANUF  = 20'h0_0000;
  localparam logic [ADDR_W-1:0] ADDR_ID_DEVICE = 20'h0_0001;
  localparam logic [ADDR_W-1:0] ADDR_ID_EXTRA  = 20'h0_0003;
  localparam logic [7:0] CODE_UNLOCK1  = 8'hAA;
  localparam logic [7:0] CODE_UNLOCK2  = 8'h55;
  localparam logic [7:0] CODE_PROGRAM  = 8'hA0;
  localparam logic [7:0] CODE_ERASE    = 8'h80;
  localparam logic [7:0] CODE_CHIP     = 8'h10;
  localparam logic [7:0] CODE_SECTOR   = 8'h30;
  localparam logic [7:0] CODE_SUSPEND  = 8'hB0;
  localparam logic [7:0] CODE_RESUME   = 8'h30;
  localparam logic [7:0] CODE_ID_ENTER = 8'h90;
  localparam logic [7:0] CODE_ID_EXIT  = 8'hF0;
  localparam int         TOGGLE_BIT    = 6;

  // ==========================================================================
  // Times and cycle counts
  localparam int CLK_NS          = 50;
  localparam int CYC_PER_US      = 1000 / CLK_NS;
  localparam int CYC_PER_MS      = 1000000 / CLK_NS;
  localparam int WP_NS           = 40;
  localparam int ACC_NS          = 70;
  localparam int OEHP_NS         = 50;
  localparam int AH_NS           = 40;
  localparam int PROG_MAX_US     = 200;
  localparam int PROG_VPP_MAX_US = 100;
  localparam int CHIP_MAX_MS     = 12;
  localparam int CHIP_VPP_MAX_MS = 6;
  localparam int SECT_MAX_MS     = 400;
  localparam int SUSP_MAX_US     = 15;
  localparam int SYNC_CYC        = 2;
  localparam int WP_CYC          = (WP_NS + CLK_NS - 1) / CLK_NS;
  localparam int ACC_CYC         = (ACC_NS + CLK_NS - 1) / CLK_NS;
  localparam int OEHP_CYC        = (OEHP_NS + CLK_NS - 1) / CLK_NS;
  localparam int AH_CYC          = (AH_NS + CLK_NS - 1) / CLK_NS;
  localparam int RECOV_CYC       = (OEHP_CYC > AH_CYC) ? OEHP_CYC : AH_CYC;
  localparam int READ_CYC        = ACC_CYC + SYNC_CYC;
  localparam int PROG_CYC        = PROG_MAX_US * CYC_PER_US;
  localparam int PROG_VPP_CYC    = PROG_VPP_MAX_US * CYC_PER_US;
  localparam int CHIP_CYC        = CHIP_MAX_MS * CYC_PER_MS;
  localparam int CHIP_VPP_CYC    = CHIP_VPP_MAX_MS * CYC_PER_MS;
  localparam int SECT_CYC        = SECT_MAX_MS * CYC_PER_MS;
  localparam int SUSP_CYC        = SUSP_MAX_US * CYC_PER_US;

endpackage

// *** core/flash_bus_cycle.sv ***
/*
  One asynchronous flash bus cycle, read or write, on registered pins.
  Assumes start is a one-cycle pulse from logic on the same clock and that
  dqIn comes straight from the flash pins.
*/
`timescale 1ns/1ps
module flash_bus_cycle (
  // Clock and reset
  input  wire logic                               clk,
  input  wire logic                               rstn,
  // Cycle request
  input  wire logic                               start,
  input  wire logic                               isWrite,
  input  wire logic [flash_host_pkg::ADDR_W-1:0]  addr,
  input  wire logic [flash_host_pkg::DATA_W-1:0]  wdata,
  // Cycle answer
  output logic                                    done,
  output logic      [flash_host_pkg::DATA_W-1:0]  rdata,
  // Flash pins
  output flash_host_pkg::pins_t                   pins,
  input  wire logic [flash_host_pkg::DATA_W-1:0]  dqIn
);

  typedef enum logic [1:0] {B_IDLE, B_ACTIVE, B_RECOVER} bstate_t;

  bstate_t                              state_reg, state_next;
  logic    [3:0]                        cnt_reg, cnt_next;
  logic                                 wr_reg, wr_next;
  logic                                 done_reg, done_next;
  logic    [flash_host_pkg::DATA_W-1:0] rdata_reg, rdata_next;
  flash_host_pkg::pins_t                pins_reg, pins_next;
  logic    [flash_host_pkg::DATA_W-1:0] dqMeta_reg, dqSync_reg;

  // ==========================================================================
  // Next cycle state
  always_comb begin
    state_next = state_reg;
    cnt_next   = cnt_reg + 4'h1;
    wr_next    = wr_reg;
    done_next  = 1'b0;
    rdata_next = rdata_reg;
    pins_next  = pins_reg;
    case (state_reg)
      B_IDLE: begin
        cnt_next = 4'h0;
        if (start) begin
          state_next      = B_ACTIVE;
          wr_next         = isWrite;
          pins_next.addr  = addr;
          pins_next.dqOut = wdata;
          pins_next.dqOe  = isWrite;
          pins_next.ceN   = 1'b0;
          pins_next.weN   = ~isWrite;
          pins_next.oeN   = isWrite;
        end
      end
      B_ACTIVE: begin
        if (wr_reg ? (cnt_reg == 4'(flash_host_pkg::WP_CYC - 1))
                   : (cnt_reg == 4'(flash_host_pkg::READ_CYC))) begin
          state_next    = B_RECOVER;
          cnt_next      = 4'h0;
          rdata_next    = wr_reg ? rdata_reg : dqSync_reg;
          pins_next.ceN = 1'b1;
          pins_next.oeN = 1'b1;
          pins_next.weN = 1'b1;
        end
      end
      B_RECOVER: begin
        // Strobes high long enough for the next pulse, address still held
        if (cnt_reg == 4'(flash_host_pkg::RECOV_CYC - 1)) begin
          state_next     = B_IDLE;
          done_next      = 1'b1;
          pins_next.dqOe = 1'b0;
        end
      end
      default: state_next = B_IDLE;
    endcase
  end

  // ==========================================================================
  // Registers and data pin synchroniser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg  <= B_IDLE;
      cnt_reg    <= 4'h0;
      wr_reg     <= 1'b0;
      done_reg   <= 1'b0;
      rdata_reg  <= 16'h0000;
      pins_reg   <= '{ceN: 1'b1, oeN: 1'b1, weN: 1'b1, addr: 20'h0_0000, dqOut: 16'h0000, dqOe: 1'b0};
      dqMeta_reg <= 16'h0000;
      dqSync_reg <= 16'h0000;
    end else begin
      state_reg  <= state_next;
      cnt_reg    <= cnt_next;
      wr_reg     <= wr_next;
      done_reg   <= done_next;
      rdata_reg  <= rdata_next;
      pins_reg   <= pins_next;
      dqMeta_reg <= dqIn;
      dqSync_reg <= dqMeta_reg;
    end
  end

  assign done  = done_reg;
  assign rdata = rdata_reg;
  assign pins  = pins_reg;

endmodule // flash_bus_cycle

// *** core/flash_host_ctrl.sv ***
/*
  Host controller for an asynchronous parallel NOR flash: issues command
  sequences, polls the toggle status bit and reads array or ID data.
  Assumes the flash pins connect directly and vppHigh is an asynchronous
  level that reports the program supply at or above 4.5 V.
*/
// Functional notes
// - Chip erase ends with 10H at 555
// - Sector erase ends with 30H in sector
// - Toggle status with meeting high pulse width
// - Poll address stays constant throughout
// - Only changes of toggle bit matter
// - Command upper data byte is ignored
`timescale 1ns/1ps
module flash_host_ctrl #(
  parameter int PROG_CYC     = flash_host_pkg::PROG_CYC,
  parameter int PROG_VPP_CYC = flash_host_pkg::PROG_VPP_CYC,
  parameter int CHIP_CYC     = flash_host_pkg::CHIP_CYC,
  parameter int CHIP_VPP_CYC = flash_host_pkg::CHIP_VPP_CYC,
  parameter int SECT_CYC     = flash_host_pkg::SECT_CYC
) (
  // Clock and reset
  input  wire logic                               clk,
  input  wire logic                               rstn,
  // User request
  input  wire logic                               reqValid,
  input  flash_host_pkg::req_t                    req,
  output logic                                    reqReady,
  // User answer
  output logic                                    rspDone,
  output logic      [flash_host_pkg::DATA_W-1:0]  rspData,
  output logic                                    rspTimeout,
  // Program supply level
  input  wire logic                               vppHigh,
  // Flash pins
  output flash_host_pkg::pins_t                   pins,
  input  wire logic [flash_host_pkg::DATA_W-1:0]  dqIn
);

  typedef enum logic [2:0] {S_IDLE, S_STEP, S_STEPWAIT, S_POLL, S_POLLWAIT, S_SUSP, S_REPLY} state_t;

  state_t                              state_reg, state_next;
  flash_host_pkg::req_t                req_reg, req_next;
  logic    [2:0]                       idx_reg, idx_next;
  logic    [flash_host_pkg::TO_W-1:0]  cnt_reg, cnt_next;
  logic                                first_reg, first_next;
  logic                                prev_reg, prev_next;
  logic                                ready_reg, ready_next;
  logic                                done_reg, done_next;
  logic                                tout_reg, tout_next;
  logic    [flash_host_pkg::DATA_W-1:0] data_reg, data_next;
  logic                                vppMeta_reg, vppSync_reg;
  logic                                engStart, engWrite, engDone;
  logic    [flash_host_pkg::ADDR_W-1:0] engAddr;
  logic    [flash_host_pkg::DATA_W-1:0] engData, engRdata;
  flash_host_pkg::step_t               step;

  localparam int TO_W = flash_host_pkg::TO_W;

  // ==========================================================================
  // Command byte with the upper data byte held at zero
  function automatic logic [flash_host_pkg::DATA_W-1:0] cmdWord(input logic [7:0] code);
    return {8'h00, code};
  endfunction

  // One step of the command sequence for a request
  function automatic flash_host_pkg::step_t cmdStep(input flash_host_pkg::req_t r, input logic [2:0] i);
    flash_host_pkg::step_t s;
    logic [7:0]            code;
    s      = '{addr: flash_host_pkg::ADDR_UNLOCK1, data: 16'h0000, isWrite: 1'b1, last: 1'b0};
    code   = 8'h00;
    // Unlock pairs open every sequence except reads, suspend, resume and the short ID exit
    case (i)
      3'd0, 3'd3: code = flash_host_pkg::CODE_UNLOCK1;
      3'd1, 3'd4: begin
        code   = flash_host_pkg::CODE_UNLOCK2;
        s.addr = flash_host_pkg::ADDR_UNLOCK2;
      end
      default: code = 8'h00;
    endcase
    case (r.cmd)
      flash_host_pkg::CMD_PROGRAM: begin
        if (i == 3'd2) code = flash_host_pkg::CODE_PROGRAM;
        s.last = (i == 3'd3);
      end
      flash_host_pkg::CMD_CHIP_ERASE, flash_host_pkg::CMD_SECTOR_ERASE: begin
        if (i == 3'd2) code = flash_host_pkg::CODE_ERASE;
        if (i == 3'd5) begin
          if (r.cmd == flash_host_pkg::CMD_CHIP_ERASE) begin
            code = flash_host_pkg::CODE_CHIP;
          end else begin
            code   = flash_host_pkg::CODE_SECTOR;
            s.addr = r.addr;
          end
        end
        s.last = (i == 3'd5);
      end
      flash_host_pkg::CMD_ID_ENTER, flash_host_pkg::CMD_ID_EXIT_LONG: begin
        if (i == 3'd2) begin
          code = (r.cmd == flash_host_pkg::CMD_ID_ENTER) ? flash_host_pkg::CODE_ID_ENTER
                                                         : flash_host_pkg::CODE_ID_EXIT;
        end
        s.last = (i == 3'd2);
      end
      flash_host_pkg::CMD_ID_EXIT_SHORT: begin
        code   = flash_host_pkg::CODE_ID_EXIT;
        s.last = 1'b1;
      end
      flash_host_pkg::CMD_SUSPEND, flash_host_pkg::CMD_RESUME: begin
        code   = (r.cmd == flash_host_pkg::CMD_SUSPEND) ? flash_host_pkg::CODE_SUSPEND
                                                        : flash_host_pkg::CODE_RESUME;
        s.addr = r.addr;
        s.last = 1'b1;
      end
      default: begin
        // Array or ID read; ID codes sit at 0000H, 0001H, 0003H
        s.addr    = r.addr;
        s.isWrite = 1'b0;
        s.last    = 1'b1;
      end
    endcase
    s.data = cmdWord(code);
    if (r.cmd == flash_host_pkg::CMD_PROGRAM && i == 3'd3) begin
      s.addr = r.addr;
      s.data = r.data;
    end
    return s;
  endfunction

  // Longest wait before an embedded operation is declared stuck
  function automatic logic [flash_host_pkg::TO_W-1:0] timeLimit(input flash_host_pkg::cmd_t c, input logic fast);
    case (c)
      flash_host_pkg::CMD_PROGRAM:    return fast ? TO_W'(PROG_VPP_CYC) : TO_W'(PROG_CYC);
      flash_host_pkg::CMD_CHIP_ERASE: return fast ? TO_W'(CHIP_VPP_CYC) : TO_W'(CHIP_CYC);
      default:                        return TO_W'(SECT_CYC);
    endcase
  endfunction

  assign step = cmdStep(req_reg, idx_reg);

  // ==========================================================================
  // Sequencer next state
  always_comb begin
    state_next = state_reg;
    req_next   = req_reg;
    idx_next   = idx_reg;
    cnt_next   = cnt_reg;
    first_next = first_reg;
    prev_next  = prev_reg;
    done_next  = 1'b0;
    tout_next  = tout_reg;
    data_next  = data_reg;
    engStart   = 1'b0;
    engWrite   = step.isWrite;
    engAddr    = step.addr;
    engData    = step.data;
    case (state_reg)
      S_IDLE: begin
        if (reqValid) begin
          req_next   = req;
          idx_next   = 3'd0;
          tout_next  = 1'b0;
          state_next = S_STEP;
        end
      end
      S_STEP: begin
        engStart   = 1'b1;
        state_next = S_STEPWAIT;
      end
      S_STEPWAIT: begin
        if (engDone) begin
          cnt_next   = '0;
          first_next = 1'b1;
          if (!step.last) begin
            idx_next   = idx_reg + 3'd1;
            state_next = S_STEP;
          end else begin
            case (req_reg.cmd)
              flash_host_pkg::CMD_PROGRAM, flash_host_pkg::CMD_CHIP_ERASE,
              flash_host_pkg::CMD_SECTOR_ERASE: state_next = S_POLL;
              flash_host_pkg::CMD_SUSPEND:      state_next = S_SUSP;
              flash_host_pkg::CMD_READ: begin
                data_next  = engRdata;
                state_next = S_REPLY;
              end
              default: state_next = S_REPLY;
            endcase
          end
        end
      end
      S_POLL: begin
        // Status read at the request address, the same on every read
        engStart   = 1'b1;
        engWrite   = 1'b0;
        engAddr    = req_reg.addr;
        state_next = S_POLLWAIT;
        cnt_next   = cnt_reg + TO_W'(1);
      end
      S_POLLWAIT: begin
        cnt_next = cnt_reg + TO_W'(1);
        if (engDone) begin
          prev_next  = engRdata[flash_host_pkg::TOGGLE_BIT];
          first_next = 1'b0;
          data_next  = engRdata;
          // Two reads in a row with the same toggle bit mean the operation has ended
          if (!first_reg && engRdata[flash_host_pkg::TOGGLE_BIT] == prev_reg) begin
            state_next = S_REPLY;
          end else if (cnt_reg >= timeLimit(req_reg.cmd, vppSync_reg)) begin
            tout_next  = 1'b1;
            state_next = S_REPLY;
          end else begin
            state_next = S_POLL;
          end
        end
      end
      S_SUSP: begin
        // Hold off until the suspend latency has surely passed
        cnt_next = cnt_reg + TO_W'(1);
        if (cnt_reg >= TO_W'(flash_host_pkg::SUSP_CYC - 1)) begin
          state_next = S_REPLY;
        end
      end
      S_REPLY: begin
        done_next  = 1'b1;
        state_next = S_IDLE;
      end
      default: state_next = S_IDLE;
    endcase
    ready_next = (state_next == S_IDLE);
  end

  // ==========================================================================
  // Sequencer registers and supply level synchroniser
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      state_reg   <= S_IDLE;
      req_reg     <= '{cmd: flash_host_pkg::CMD_READ, addr: 20'h0_0000, data: 16'h0000};
      idx_reg     <= 3'd0;
      cnt_reg     <= '0;
      first_reg   <= 1'b1;
      prev_reg    <= 1'b0;
      ready_reg   <= 1'b1;
      done_reg    <= 1'b0;
      tout_reg    <= 1'b0;
      data_reg    <= 16'h0000;
      vppMeta_reg <= 1'b0;
      vppSync_reg <= 1'b0;
    end else begin
      state_reg   <= state_next;
      req_reg     <= req_next;
      idx_reg     <= idx_next;
      cnt_reg     <= cnt_next;
      first_reg   <= first_next;
      prev_reg    <= prev_next;
      ready_reg   <= ready_next;
      done_reg    <= done_next;
      tout_reg    <= tout_next;
      data_reg    <= data_next;
      vppMeta_reg <= vppHigh;
      vppSync_reg <= vppMeta_reg;
    end
  end

  // ==========================================================================
  // Pin cycle engine
  flash_bus_cycle uCycle (
    .clk     (clk),
    .rstn    (rstn),
    .start   (engStart),
    .isWrite (engWrite),
    .addr    (engAddr),
    .wdata   (engData),
    .done    (engDone),
    .rdata   (engRdata),
    .pins    (pins),
    .dqIn    (dqIn)
  );

  assign reqReady   = ready_reg;
  assign rspDone    = done_reg;
  assign rspData    = data_reg;
  assign rspTimeout = tout_reg;

endmodule // flash_host_ctrl

// *** tb/flash_host_ctrl_chk.sv ***
/*
  Port checker for the flash host controller.
  Assumes a bind onto flash_host_ctrl and one clock.
*/
`timescale 1ns/1ps
module flash_host_ctrl_chk (
  // Clock and reset
  input wire logic             clk,
  input wire logic             rstn,
  // User side
  input wire logic             reqValid,
  input wire logic             reqReady,
  input wire logic             rspDone,
  input wire logic             rspTimeout,
  // Flash side
  input flash_host_pkg::pins_t pins
);
  // ==========================================================================
  // Handshake
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  property p_answer; reqValid && reqReady |=> !reqReady ##[0:999] rspDone; endproperty
  a_answer: assert property (p_answer) else $error("no answer in time");
  property p_done; rspDone |-> reqReady ##1 !rspDone; endproperty
  a_done: assert property (p_done) else $error("done not a pulse");
  property p_tmo; $rose(rspTimeout) |=> rspDone; endproperty
  a_tmo: assert property (p_tmo) else $error("timeout without done");
  property p_idle; reqReady |-> pins.ceN && pins.oeN && pins.weN; endproperty
  a_idle: assert property (p_idle) else $error("strobe low while idle");
  // ==========================================================================
  // Pin cycles
  property p_wr; !pins.weN |-> !pins.ceN && pins.oeN && pins.dqOe; endproperty
  a_wr: assert property (p_wr) else $error("bad write strobes");
  property p_wp; $fell(pins.weN) |=> pins.weN; endproperty
  a_wp: assert property (p_wp) else $error("write pulse not one cycle");
  property p_unl2; !pins.weN && pins.addr == flash_host_pkg::ADDR_UNLOCK2 |-> pins.dqOut == 16'h0055; endproperty
  a_unl2: assert property (p_unl2) else $error("bad second unlock word");
  property p_unl1; !pins.weN && pins.addr == flash_host_pkg::ADDR_UNLOCK1 |-> pins.dqOut[15:8] == 8'h00; endproperty
  a_unl1: assert property (p_unl1) else $error("upper byte not zero");
  property p_rdaddr; !pins.oeN && $past(!pins.oeN) |-> $stable(pins.addr); endproperty
  a_rdaddr: assert property (p_rdaddr) else $error("address moved during read");
  property p_ceoe; $rose(pins.oeN) |-> pins.ceN && !pins.dqOe; endproperty
  a_ceoe: assert property (p_ceoe) else $error("bad read end");
  // Main scenarios
  c_tmo: cover property (rspDone && rspTimeout);
  c_chip: cover property (!pins.weN && pins.dqOut == 16'h0010);
  c_poll: cover property ($rose(pins.oeN) ##[1:4] $fell(pins.oeN));
endmodule // flash_host_ctrl_chk

bind flash_host_ctrl flash_host_ctrl_chk chk (.clk(clk), .rstn(rstn), .reqValid(reqValid), .reqReady(reqReady),
  .rspDone(rspDone), .rspTimeout(rspTimeout), .pins(pins));

// *** tb/flash_dev_model.sv ***
/*
  Behavioural flash: commands, busy status, ID mode, array.
  Assumes registered host pins; samples on the falling edge.
*/
`timescale 1ns/1ps
module flash_dev_model #(
  parameter logic [15:0] MANUF_CODE = 16'h005A, // Arbitrary value
  parameter logic [15:0] DEV_CODE   = 16'h0033, // Arbitrary value
  parameter logic [15:0] EXTRA_CODE = 16'h0044, // Arbitrary value
  parameter int          BUSY_LEN   = 40
) (
  // Sampling clock
  input wire logic        clk,
  // Host pins
  input flash_host_pkg::pins_t pins,
  output logic [15:0]     dqIn,
  // Test control and faults seen
  input wire logic        stuck,
  output int              errs
);
  logic [15:0] mem [int];
  int          busy = 0, seq = 0, ks[$];
  wire         rd = !pins.ceN && !pins.oeN;
  logic        idMode = 1'b0;
  logic        prog = 0, susp = 0, tog = 0, rdPrev = 0, pollSet = 0;
  logic [15:0] last = 16'h0000;
  logic [19:0] pollA;
  logic [7:0]  c;

  initial errs = 0;
  // Read data, busy status, inverse when released
  always @* begin
    if (!rd) dqIn = ~last;
    else if (busy > 0 && !susp) dqIn = {9'h000, tog, 6'h00};
    else if (idMode && pins.addr[19:1] == 0) dqIn = pins.addr[0] ? DEV_CODE : MANUF_CODE;
    else if (idMode && pins.addr == 20'h0_0003) dqIn = EXTRA_CODE;
    else dqIn = mem.exists(pins.addr) ? mem[pins.addr] : 16'hFFFF;
  end
  // Busy count, toggle status and command decode
  always @(negedge clk) begin
    if (rd) last = dqIn;
    if (busy > 0 && !susp && !stuck) busy--;
    if (rd && !rdPrev && busy > 0) begin
      if (pollSet && pollA !== pins.addr) errs++;
      pollA = pins.addr;
      pollSet = 1;
      tog = ~tog;
    end
    rdPrev = rd;
    if (!pins.ceN && !pins.weN) begin
      c = pins.dqOut[7:0];
      if (prog) begin
        mem[pins.addr] = pins.dqOut;
        busy = BUSY_LEN;
        pollSet = 0;
        prog = 0;
      end else begin
        if (pins.dqOut[15:8] != 8'h00) errs++;
        case (seq)
          0: begin
            if (c == 8'hB0) susp = 1;
            if (c == 8'h30) susp = 0;
            if (c == 8'hF0) idMode = 0;
            seq = (c == 8'hAA && pins.addr == 20'h0_0555) ? 1 : 0;
          end
          1: seq = (c == 8'h55 && pins.addr == 20'h0_02AA) ? 2 : 0;
          2: begin
            prog = c == 8'hA0;
            if (c == 8'h90) idMode = 1;
            if (c == 8'hF0) idMode = 0;
            seq = c == 8'h80 ? 3 : 0;
          end
          3: seq = c == 8'hAA ? 4 : 0;
          4: seq = c == 8'h55 ? 5 : 0;
          default: begin
            if (c == 8'h10 && pins.addr == 20'h0_0555) mem.delete();
            ks.delete();
            if (c == 8'h30) foreach (mem[k]) if ((k >> 15) == (pins.addr >> 15)) ks.push_back(k);
            foreach (ks[i]) mem.delete(ks[i]);
            busy = BUSY_LEN;
            pollSet = 0;
            seq = 0;
          end
        endcase
      end
    end
  end
endmodule // flash_dev_model

// *** tb/flash_host_ctrl_tb.sv ***
/*
  Self-checking bench: host controller and flash model.
  Assumes the checker binds itself; small time-out limits.
*/
`timescale 1ns/1ps
module flash_host_ctrl_tb;
  localparam int          PL = 200, PVL = 100, CL = 400, CVL = 300, SL = 300;
  localparam logic [19:0] BADR = 20'h0_0C00;
  logic                   clk = 0, rstn = 0, reqValid = 0, vppHigh = 0, stuck = 0;
  logic                   reqReady, rspDone, rspTimeout, gotTmo;
  flash_host_pkg::req_t   req = '0;
  flash_host_pkg::pins_t  pins;
  logic [15:0]            rspData, dqIn, got, dt;
  logic [19:0]            ad;
  int                     errs, cyc, lim, seed = 9874, fail_count = 0, cmp_count = 0;

  flash_host_ctrl #(.PROG_CYC(PL), .PROG_VPP_CYC(PVL), .CHIP_CYC(CL), .CHIP_VPP_CYC(CVL), .SECT_CYC(SL)) uut (
    .clk(clk), .rstn(rstn), .reqValid(reqValid), .req(req), .reqReady(reqReady), .rspDone(rspDone),
    .rspData(rspData), .rspTimeout(rspTimeout), .vppHigh(vppHigh), .pins(pins), .dqIn(dqIn));
  flash_dev_model dev (.clk(clk), .pins(pins), .dqIn(dqIn), .stuck(stuck), .errs(errs));

  // 20 MHz clock
  initial begin
    forever #25 clk = ~clk;
  end
  // ==========================================================================
  // Shared tasks
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic summarize();
    $display("Comparisons %0d, mismatches %0d", cmp_count, fail_count);
    if (fail_count == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  task automatic cycles(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // One request; cyc counts take to done
  task automatic run(input flash_host_pkg::cmd_t c, input logic [19:0] a, input logic [15:0] d);
    int n;
    for (n = 0; reqReady !== 1'b1 && n < 5000; n++) cycles(1);
    req = '{cmd: c, addr: a, data: d};
    reqValid = 1;
    cycles(1);
    reqValid = 0;
    for (cyc = 1; rspDone !== 1'b1 && cyc < 5000; cyc++) cycles(1);
    if (cyc >= 5000 || n >= 5000) begin
      fail_count++;
      $display("CHECK FAILED t=%0t no answer", $time);
      summarize();
    end
    got = rspData;
    gotTmo = rspTimeout;
    cycles(1);
  endtask
  // ==========================================================================
  // Main sequence
  initial begin
    cycles(8);
    rstn = 1;
    cycles(1);
    check({pins.ceN, pins.oeN, pins.weN, pins.dqOe, reqReady, rspDone}, 6'b111010);
    $display("test reset");
    // Random program and read back
    for (int i = 0; i < 4; i++) begin
      ad = 20'($random(seed)) | 20'h8_0C00;
      dt = 16'($random(seed));
      vppHigh = i[0];
      cycles(4);
      run(flash_host_pkg::CMD_PROGRAM, ad, dt);
      check({gotTmo, cyc < (i[0] ? PVL : PL)}, 2'b01);
      run(flash_host_pkg::CMD_READ, ad, 16'h0000);
      check(got, dt);
    end
    $display("test program");
    // Sector erase keeps the other sector
    run(flash_host_pkg::CMD_PROGRAM, BADR, 16'hA5C3);
    run(flash_host_pkg::CMD_SECTOR_ERASE, ad, 16'h0000);
    check({gotTmo, cyc < SL}, 2'b01);
    run(flash_host_pkg::CMD_READ, ad, 16'h0000);
    check(got, 16'hFFFF);
    run(flash_host_pkg::CMD_READ, BADR, 16'h0000);
    check(got, 16'hA5C3);
    // Chip erase on the fast supply
    run(flash_host_pkg::CMD_CHIP_ERASE, flash_host_pkg::ADDR_UNLOCK1, 16'h0000);
    check({gotTmo, cyc < CVL}, 2'b01);
    run(flash_host_pkg::CMD_READ, BADR, 16'h0000);
    check(got, 16'hFFFF);
    $display("test erase");
    // ID codes, then each exit form
    for (int i = 0; i < 2; i++) begin
      run(flash_host_pkg::CMD_ID_ENTER, flash_host_pkg::ADDR_UNLOCK1, 16'h0000);
      for (int j = 0; j < 3; j++) begin
        run(flash_host_pkg::CMD_READ, 20'(j == 2 ? 3 : j), 16'h0000);
        check(got, j == 0 ? dev.MANUF_CODE : j == 1 ? dev.DEV_CODE : dev.EXTRA_CODE);
      end
      run(i ? flash_host_pkg::CMD_ID_EXIT_LONG : flash_host_pkg::CMD_ID_EXIT_SHORT, BADR, 16'h0000);
      run(flash_host_pkg::CMD_READ, flash_host_pkg::ADDR_ID_MANUF, 16'h0000);
      check(got, 16'hFFFF);
    end
    $display("test id");
    // Suspend wait, then resume
    run(flash_host_pkg::CMD_SUSPEND, BADR, 16'h0000);
    check(cyc >= flash_host_pkg::SUSP_CYC && cyc <= flash_host_pkg::SUSP_CYC + 20, 1'b1);
    run(flash_host_pkg::CMD_RESUME, BADR, 16'h0000);
    $display("test suspend");
    // Stuck device: poll limit per supply
    stuck = 1;
    for (int i = 0; i < 2; i++) begin
      vppHigh = i[0];
      cycles(4);
      lim = i ? PVL : PL;
      run(flash_host_pkg::CMD_PROGRAM, BADR, 16'h1234);
      check({gotTmo, cyc >= lim && cyc <= lim + 40}, 2'b11);
    end
    stuck = 0;
    cycles(60);
    check(errs, 0);
    $display("test timeout");
    summarize();
  end
endmodule // flash_host_ctrl_tb
